// file: design/rro_exec.sv
// Execution unit for the return and rotate operations of an 8-bit core.
// Assumes the decoder pulses op_valid for one cycle with the operation and its
// immediate, and that mem_rdata already holds the addressed byte in that cycle.
`timescale 1ns/10ps
module rro_exec
	import rro_pkg::*;
#(
	parameter int PC_W = 10,
	parameter int STACK_DEPTH = 8,
	parameter int SP_W = 3,
	parameter logic [PC_W-1:0] IRQ_VECTOR = 10'h004
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic op_valid,
	input wire rro_op_t op_code,
	input wire logic [7:0] op_imm,
	input wire logic [7:0] mem_rdata,
	input wire logic irq_pending,
	input wire logic call_push,
	input wire logic [PC_W-1:0] call_addr,
	output logic busy,
	output logic [7:0] working_register,
	output logic carry,
	output logic master_interrupt_enable,
	output logic pc_load,
	output logic [PC_W-1:0] pc_value,
	output logic mem_we,
	output logic [7:0] mem_wdata,
	output logic irq_take,
	output logic [SP_W-1:0] stack_ptr
);

	// ======================================================================
	// Assertion clock and reset for the whole unit
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	// ======================================================================
	// Sequencer state
	typedef enum logic {ST_RUN, ST_IRQ_ENTRY} rro_state_t;
	rro_state_t state;
	rro_state_t next_state;

	// ======================================================================
	// Decode, as named wires
	logic take;
	logic is_ret_lit;
	logic is_ret_int;
	logic is_return;
	logic is_rotlc;
	logic mem_write_op;
	logic work_write_op;
	logic stack_push;
	logic [PC_W-1:0] stack_top;
	logic [PC_W-1:0] push_value;

	// Operations are only taken while not entering a handler
	assign take = op_valid && state == ST_RUN;
	assign is_ret_lit = take && op_code == OP_RETURN_LIT;
	assign is_ret_int = take && op_code == OP_RETURN_INT;
	assign is_return = is_ret_lit || is_ret_int;
	assign is_rotlc = take && (op_code == OP_ROTLC_MEM || op_code == OP_ROTLC_WORK);
	assign mem_write_op = take && (op_code == OP_ROTL_MEM || op_code == OP_ROTLC_MEM
		|| op_code == OP_ROTR_MEM);
	assign work_write_op = take && (op_code == OP_ROTL_WORK || op_code == OP_ROTLC_WORK);

	// ======================================================================
	// Rotation results
	logic [7:0] rotl;
	logic [7:0] rotlc;
	logic [7:0] rotr;
	logic mem_msb;
	logic [7:0] next_rot;

	assign rotl = {mem_rdata[BYTE_MSB-1:BYTE_LSB], mem_rdata[BYTE_MSB]};
	assign rotlc = {mem_rdata[BYTE_MSB-1:BYTE_LSB], carry};
	assign rotr = {mem_rdata[BYTE_LSB], mem_rdata[BYTE_MSB:BYTE_LSB+1]};
	assign mem_msb = mem_rdata[BYTE_MSB];
	// Same rotators serve memory and work forms; only the destination differs
	assign next_rot = (op_code == OP_ROTR_MEM) ? rotr :
		(op_code == OP_ROTLC_MEM || op_code == OP_ROTLC_WORK) ? rotlc : rotl;

	// ======================================================================
	// Return stack; handler entry pushes the address just restored
	assign stack_push = (call_push && state == ST_RUN && !is_return)
		|| state == ST_IRQ_ENTRY;
	assign push_value = (state == ST_IRQ_ENTRY) ? pc_value : call_addr;
	assign next_state = (is_ret_int && irq_pending) ? ST_IRQ_ENTRY : ST_RUN;

	rro_ret_stack #(
		.DEPTH(STACK_DEPTH),
		.AW(SP_W),
		.PW(PC_W)
	) u_stack (
		.clock(clock),
		.rst(rst),
		.clk_en(clk_en),
		.push(stack_push),
		.pop(is_return),
		.push_data(push_value),
		.top_data(stack_top),
		.sp(stack_ptr)
	);

	// Sequencer and one-cycle strobes
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			state <= ST_RUN;
			busy <= 1'b0;
			pc_load <= 1'b0;
			irq_take <= 1'b0;
			mem_we <= 1'b0;
		end
		else if (clk_en)
		begin
			state <= next_state;
			busy <= next_state == ST_IRQ_ENTRY;
			pc_load <= is_return || state == ST_IRQ_ENTRY;
			irq_take <= state == ST_IRQ_ENTRY;
			mem_we <= mem_write_op;
		end
	end

	// Target address: popped entry on return, vector on handler entry
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			pc_value <= '0;
		else if (clk_en && is_return)
			pc_value <= stack_top;
		else if (clk_en && state == ST_IRQ_ENTRY)
			pc_value <= IRQ_VECTOR;
	end

	// Memory write data; memory forms only, work forms leave memory alone
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			mem_wdata <= WORK_RST;
		else if (clk_en && mem_write_op)
			mem_wdata <= next_rot;
	end

	// Work register
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			working_register <= WORK_RST;
		else if (clk_en && is_ret_lit)
			working_register <= op_imm;
		else if (clk_en && work_write_op)
			working_register <= next_rot;
	end

	// Carry: only the through-carry forms touch it
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			carry <= CARRY_RST;
		else if (clk_en && is_rotlc)
			carry <= mem_msb;
	end

	// Master enable: set by the return from interrupt, cleared again on handler entry
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			master_interrupt_enable <= MIE_RST;
		else if (clk_en && is_ret_int)
			master_interrupt_enable <= MIE_SET;
		else if (clk_en && state == ST_IRQ_ENTRY)
			master_interrupt_enable <= MIE_RST;
	end

	// ======================================================================
	// Checks
	logic [SP_W-1:0] sp_less;
	assign sp_less = stack_ptr - SP_W'(1);

	AST_RET_LIT: assert property (clk_en && is_ret_lit |=>
		pc_load && pc_value == $past(stack_top) && working_register == $past(op_imm)
		&& $stable(carry))
		else $error("return with literal result wrong");

	AST_RET_INT: assert property (clk_en && is_ret_int |=>
		pc_load && master_interrupt_enable && $stable(carry))
		else $error("return from interrupt did not set enable");

	AST_PEND: assert property (clk_en && is_ret_int && irq_pending ##1 clk_en |=>
		irq_take && pc_load && pc_value == IRQ_VECTOR && !master_interrupt_enable)
		else $error("pending request not entered after return");

	AST_ROTL_MEM: assert property (clk_en && take && op_code == OP_ROTL_MEM |=>
		mem_we && mem_wdata == $past(rotl) && $stable(carry))
		else $error("rotate left in place wrong");

	AST_ROTL_WORK: assert property (clk_en && take && op_code == OP_ROTL_WORK |=>
		!mem_we && working_register == $past(rotl))
		else $error("rotate left to work wrong");

	AST_ROTLC_MEM: assert property (clk_en && take && op_code == OP_ROTLC_MEM |=>
		mem_we && mem_wdata == $past(rotlc) && carry == $past(mem_msb))
		else $error("rotate through carry in place wrong");

	AST_ROTLC_WORK: assert property (clk_en && take && op_code == OP_ROTLC_WORK |=>
		!mem_we && working_register == $past(rotlc) && carry == $past(mem_msb))
		else $error("rotate through carry to work wrong");

	AST_FLAGS: assert property (!(clk_en && is_rotlc) |=> $stable(carry))
		else $error("carry changed by another operation");

	AST_ROTR_MEM: assert property (clk_en && take && op_code == OP_ROTR_MEM |=>
		mem_we && mem_wdata == $past(rotr) && $stable(carry))
		else $error("rotate right in place wrong");

	AST_POP: assert property (clk_en && is_return |=> stack_ptr == $past(sp_less))
		else $error("return did not pop one entry");

	COV_RETURN_FROM_INTERRUPT_PEND: cover property (clk_en && is_ret_int && irq_pending ##2 irq_take);
	COV_ROTLC: cover property (clk_en && is_rotlc && mem_msb != carry);
	COV_RET_LIT: cover property (clk_en && is_ret_lit ##1 pc_load);

endmodule : rro_exec

// file: design/rro_pkg.sv
// Shared constants and opcode type for the return and rotate execution unit.
// Assumes the core decoder presents one decoded operation per op_valid pulse.
package rro_pkg;

	// ======================================================================
	// Operations handled by this unit
	typedef enum logic [2:0] {
		OP_RETURN_LIT,
		OP_RETURN_INT,
		OP_ROTL_MEM,
		OP_ROTL_WORK,
		OP_ROTLC_MEM,
		OP_ROTLC_WORK,
		OP_ROTR_MEM,
		OP_NONE
	} rro_op_t;

	// ======================================================================
	// Field positions and reset values
	localparam int BYTE_MSB = 7;
	localparam int BYTE_LSB = 0;
	localparam logic [7:0] WORK_RST = 8'h00;
	localparam logic CARRY_RST = 1'b0;
	localparam logic MIE_RST = 1'b0;
	localparam logic MIE_SET = 1'b1;

endpackage : rro_pkg

// file: design/rro_ret_stack.sv
// Hardware return stack held in flip-flops.
// Assumes push and pop never come in the same cycle; the pointer wraps when full.
`timescale 1ns/10ps
module rro_ret_stack
	import rro_pkg::*;
#(
	parameter int DEPTH = 8,
	parameter int AW = 3,
	parameter int PW = 10
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic push,
	input wire logic pop,
	input wire logic [PW-1:0] push_data,
	output logic [PW-1:0] top_data,
	output logic [AW-1:0] sp
);

	// ======================================================================
	// Storage and pointer
	logic [PW-1:0] entry [DEPTH];
	logic [AW-1:0] top_idx;
	logic [AW-1:0] next_sp;

	// Pointer names the next free slot, so the top is one below it
	assign top_idx = sp - AW'(1);
	assign top_data = entry[top_idx];
	assign next_sp = push ? sp + AW'(1) : (pop ? top_idx : sp);

	// Pointer register
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			sp <= '0;
		else if (clk_en)
			sp <= next_sp;
	end

	// One write port per entry, selected by the pointer
	for (genvar g = 0; g < DEPTH; g++)
	begin : g_entry
		always_ff @(posedge clock or posedge rst)
		begin
			if (rst)
				entry[g] <= '0;
			else if (clk_en && push && sp == AW'(g))
				entry[g] <= push_data;
		end
	end

endmodule : rro_ret_stack

// file: verif/return_and_rotate_ops_tb_top.sv
// Self-checking bench for the return and rotate execution unit.
// Assumes rro_exec drives registered outputs one cycle after each taken operation.
`timescale 1ns/10ps
module return_and_rotate_ops_tb_top
	import rro_pkg::*;
;
	localparam logic [9:0] VEC = 10'h004;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic clk_en = 1'b1;
	logic op_valid = 1'b0;
	rro_op_t op_code = OP_NONE;
	logic [7:0] op_imm = 8'h00;
	logic [7:0] mem_rdata = 8'h00;
	logic irq_pending = 1'b0;
	logic call_push = 1'b0;
	logic [9:0] call_addr = 10'h000;
	logic busy, carry, mie, pc_load, mem_we, irq_take;
	logic [7:0] wr, mem_wdata;
	logic [9:0] pc_value;
	logic [2:0] stack_ptr;
	int fails = 0;
	int comparisons = 0;

	rro_exec #(.IRQ_VECTOR(VEC)) uut (.clock(clock), .rst(rst), .clk_en(clk_en),
		.op_valid(op_valid), .op_code(op_code), .op_imm(op_imm), .mem_rdata(mem_rdata),
		.irq_pending(irq_pending), .call_push(call_push), .call_addr(call_addr),
		.busy(busy), .working_register(wr), .carry(carry), .master_interrupt_enable(mie),
		.pc_load(pc_load), .pc_value(pc_value), .mem_we(mem_we), .mem_wdata(mem_wdata),
		.irq_take(irq_take), .stack_ptr(stack_ptr));

	// ======================================================================
	// Clock and shared helpers
	always #50 clock = ~clock;

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Drives one op before the taking edge; returns in the answer cycle
	task automatic op(input rro_op_t c, input logic [7:0] imm, input logic [7:0] rd);
		@(negedge clock);
		op_valid = 1'b1;
		op_code = c;
		op_imm = imm;
		mem_rdata = rd;
		@(negedge clock);
		op_valid = 1'b0;
	endtask : op

	task automatic push(input logic [9:0] a);
		@(negedge clock);
		call_push = 1'b1;
		call_addr = a;
		@(negedge clock);
		call_push = 1'b0;
	endtask : push

	task automatic final_report;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report

	// ======================================================================
	// Scenarios
	task automatic t_rot_mem;
		op(OP_ROTL_MEM, 8'h00, 8'h81);
		chk("rotl", 16'h103, {mem_we, mem_wdata});
		chk("rotl carry", 16'h0, carry);
		op(OP_ROTR_MEM, 8'h00, 8'h81);
		chk("rotr", 16'h1c0, {mem_we, mem_wdata});
		op(OP_ROTLC_MEM, 8'h00, 8'h81);
		chk("rotlc", 16'h302, {carry, mem_we, mem_wdata});
		op(OP_ROTLC_MEM, 8'h00, 8'h40);
		chk("rotlc ci", 16'h181, {carry, mem_we, mem_wdata});
		chk("work kept", 16'h00, wr);
		$display("t_rot_mem done");
	endtask : t_rot_mem

	task automatic t_rot_work;
		op(OP_ROTL_WORK, 8'h00, 8'h96);
		chk("rotlw", 16'h02d, {carry, mem_we, wr});
		op(OP_ROTLC_WORK, 8'h00, 8'h80);
		chk("rotlcw", 16'h200, {carry, mem_we, wr});
		op(OP_ROTLC_WORK, 8'h00, 8'h01);
		chk("rotlcw ci", 16'h003, {carry, mem_we, wr});
		$display("t_rot_work done");
	endtask : t_rot_work

	task automatic t_ret_lit;
		push(10'h155);
		push(10'h2aa);
		chk("sp push", 16'h2, stack_ptr);
		op(OP_RETURN_LIT, 8'h5a, 8'h00);
		chk("retl pc", 16'h6aa, {pc_load, pc_value});
		chk("retl work", 16'h5a, wr);
		chk("retl sp flags", 16'h4, {stack_ptr, carry, mie});
		op(OP_RETURN_LIT, 8'ha5, 8'h00);
		chk("retl2", 16'h555, {pc_load, pc_value});
		chk("retl2 sp", 16'h0a5, {stack_ptr, wr});
		$display("t_ret_lit done");
	endtask : t_ret_lit

	task automatic t_return_from_interrupt;
		op(OP_ROTLC_WORK, 8'h00, 8'h80);
		push(10'h123);
		op(OP_RETURN_INT, 8'h00, 8'h00);
		chk("return_from_interrupt pc", 16'h523, {pc_load, pc_value});
		chk("return_from_interrupt mie", 16'h60, {carry, mie, busy, irq_take, stack_ptr});
		$display("t_return_from_interrupt done");
	endtask : t_return_from_interrupt

	task automatic t_return_from_interrupt_pend;
		push(10'h0f0);
		@(negedge clock);
		op_valid = 1'b1;
		op_code = OP_RETURN_INT;
		irq_pending = 1'b1;
		@(negedge clock);
		chk("pend c1", 16'h0f0, pc_value);
		chk("pend c1 st", 16'h18, {busy, mie, stack_ptr});
		op_code = OP_ROTL_MEM;
		mem_rdata = 8'h81;
		irq_pending = 1'b0;
		@(negedge clock);
		op_valid = 1'b0;
		chk("pend vec", {6'h00, VEC}, pc_value);
		chk("pend take", 16'hc1, {pc_load, irq_take, mie, busy, mem_we, stack_ptr});
		@(negedge clock);
		chk("pend pulses", 16'h0, {pc_load, irq_take, mem_we});
		$display("t_return_from_interrupt_pend done");
	endtask : t_return_from_interrupt_pend

	task automatic t_idle;
		clk_en = 1'b0;
		call_push = 1'b1;
		op(OP_ROTL_MEM, 8'h00, 8'h81);
		call_push = 1'b0;
		chk("frozen", 16'h1, {mem_we, stack_ptr});
		clk_en = 1'b1;
		op(OP_NONE, 8'h77, 8'h81);
		chk("none", 16'h1, {pc_load, mem_we, stack_ptr});
		chk("none work", 16'h00, wr);
		$display("t_idle done");
	endtask : t_idle

	// ======================================================================
	// Main sequence and watchdog
	initial
	begin
		repeat (20) @(negedge clock);
		rst = 1'b0;
		@(negedge clock);
		chk("reset", 16'h0, {wr, carry, mie, stack_ptr, pc_load, mem_we});
		t_rot_mem();
		t_rot_work();
		t_ret_lit();
		t_return_from_interrupt();
		t_return_from_interrupt_pend();
		t_idle();
		final_report();
	end

	// Whole run is under 100 cycles past reset; 1000 leaves ample margin
	initial
	begin
		repeat (1000) @(posedge clock);
		fails++;
		final_report();
	end
endmodule : return_and_rotate_ops_tb_top
